// ---- common/lfs_consts.svh ----
// Constants for the lock, fuse and signature store.
// Assumes inclusion by bare name from the design file.
// Function
// - Two lock bits, erased only by chip erase
// - Lock byte bits 1,0; upper bits read 1
// - Self-programming allowed only when fuse reads 0
// - Debug fuse lets flash read despite locks
// - Mode 1 applies no lock restrictions
// - Mode 2 blocks programming, fuses, debug link
// - Mode 3 also blocks verification readout
// - Three fuse bytes, programmed reads 0
// - Reset-pin fuse forces high-voltage programming only
// - Serial enable fuse defaults programmed, serial-locked
// - Watchdog fuse forces watchdog on, no interrupt
// - Preserve fuse keeps EEPROM through chip erase
// - High byte bits 2..0 brown-out level
// - Low byte bit 6 drives clock out
// - Clock select defaults 0010, divide-eight programmed
// - Start-up field defaults 1 and 0
// - First lock bit freezes fuses; erase keeps fuses
// - Fuses latched at power-up, mode entry and mode exit
// - Preserve fuse acts immediately
// - Signature bytes at 0,2,4; calibration at 1
// - Other table addresses reserved
// - Readout index: low 0, lock 1, ext 2, high 3
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH

// Firmware readout indices
`define LFS_IDX_LOW 16'h0000
`define LFS_IDX_LOCK 16'h0001
`define LFS_IDX_EXT 16'h0002
`define LFS_IDX_HIGH 16'h0003

// Signature table addresses
`define LFS_SIG_ID0 6'h00
`define LFS_SIG_CAL 6'h01
`define LFS_SIG_ID1 6'h02
`define LFS_SIG_ID2 6'h04
`define LFS_SIG_RSVD_VAL 8'hff

// Field positions
`define LFS_EXT_SELFPRG 0
`define LFS_HIGH_RSTDIS 7
`define LFS_HIGH_DBGEN 6
`define LFS_HIGH_SERPRG 5
`define LFS_HIGH_WATCHDOG_ALWAYS_ON_FUSE 4
`define LFS_HIGH_EEKEEP 3
`define LFS_LOW_CLOCK_OUTPUT_FUSE 6
`define LFS_LOW_DIV8 7

// Reset (default) values
`define LFS_LOCK_RST 2'h3
`define LFS_LOCK_PAD 6'h3f
`define LFS_EXT_RST 8'hff
`define LFS_HIGH_RST 8'hdf
`define LFS_LOW_RST 8'h62

`endif

// ---- common/lfs_pkg.sv ----
// Types for the lock, fuse and signature store.
// Assumes lfs_consts.svh is on the include path.
package lfs_pkg;

    // Control sequencer, one-hot
    typedef enum logic [2:0] {
        LFS_ST_PWRUP = 3'b001,
        LFS_ST_RUN = 3'b010,
        LFS_ST_PROG = 3'b100
    } lfs_state_t;

    // Fuse byte selector (index encoding)
    typedef logic [1:0] lfs_sel_t;

endpackage

// ---- rtl/lfs_store.sv ----
// Lock, fuse and signature store with latched fuse outputs.
// Assumes programmer and firmware strobes are synchronous to mclk.
`timescale 1ns/1ps
`include "lfs_consts.svh"

module lfs_store #(
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'h01, // Arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h02, // Arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Programmer session
    input wire logic prog_mode,
    input wire logic prog_hv,
    input wire logic prog_fuse_wr,
    input wire lfs_pkg::lfs_sel_t prog_fuse_sel,
    input wire logic [7:0] prog_wdata,
    input wire logic prog_lock_wr,
    input wire logic prog_chip_erase,
    // Programmer permissions
    output logic prog_mem_write_ok,
    output logic prog_verify_ok,
    output logic prog_fuse_write_ok,
    output logic eeprom_erase,
    // Firmware readout
    input wire logic fw_rd,
    input wire logic fw_sig,
    input wire logic [15:0] fw_index,
    output logic [7:0] fw_rdata,
    output logic fw_rvalid,
    // Applied configuration
    output logic spm_allowed,
    output logic dbg_link_active,
    output logic dbg_flash_read_ok,
    output logic reset_pin_enabled,
    output logic wdt_forced_on,
    output logic wdt_irq_allowed,
    output logic eeprom_preserve,
    output logic [2:0] brownout_level,
    output logic clk_out_enable,
    output logic clk_div8,
    output logic [1:0] startup_time,
    output logic [3:0] clock_source,
    output logic [7:0] osc_cal
);
    import lfs_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Merge a byte write into a fuse, keeping protected bits
    function automatic logic [7:0] merge_fuse(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] keep_mask
    );
        merge_fuse = (old_val & keep_mask) | (new_val & ~keep_mask);
    endfunction

    // Select one of the three fuse bytes by index code
    function automatic logic [7:0] pick_fuse(
        input lfs_sel_t sel,
        input logic [7:0] low_v,
        input logic [7:0] ext_v,
        input logic [7:0] high_v
    );
        case (sel)
            2'h0: pick_fuse = low_v;
            2'h2: pick_fuse = ext_v;
            2'h3: pick_fuse = high_v;
            default: pick_fuse = 8'hff;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------

    // Non-volatile cells, modelled as flops reset to defaults
    logic [1:0] lock_bits_reg;
    logic [7:0] ext_nv_reg;
    logic [7:0] high_nv_reg;
    logic [7:0] low_nv_reg;

    // Latched copies that drive the device
    logic [7:0] ext_lat_reg;
    logic [7:0] high_lat_reg;
    logic [7:0] low_lat_reg;

    lfs_state_t state_reg;
    lfs_state_t state_next;
    logic latch_now;

    logic first_lock_bit;
    logic second_lock_bit;
    logic mode1;
    logic locked_fuses;
    logic fuse_wr_ok;
    logic [7:0] keep_mask;
    logic [7:0] memory_lock_byte;

    assign first_lock_bit = lock_bits_reg[0];
    assign second_lock_bit = lock_bits_reg[1];

    assign memory_lock_byte = {`LFS_LOCK_PAD, second_lock_bit,
                               first_lock_bit};

    // ------------------------------------------------------------
    // Session sequencer
    // ------------------------------------------------------------

    always_comb begin
        state_next = state_reg;
        latch_now = 1'b0;
        case (state_reg)
            LFS_ST_PWRUP: begin
                latch_now = 1'b1;
                state_next = prog_mode ? LFS_ST_PROG : LFS_ST_RUN;
            end
            LFS_ST_RUN: begin
                if (prog_mode) begin
                    latch_now = 1'b1;
                    state_next = LFS_ST_PROG;
                end
            end
            LFS_ST_PROG: begin
                if (!prog_mode) begin
                    latch_now = 1'b1;
                    state_next = LFS_ST_RUN;
                end
            end
            default: begin
                state_next = LFS_ST_PWRUP;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= LFS_ST_PWRUP;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Protection decode
    // ------------------------------------------------------------

    assign mode1 = first_lock_bit & second_lock_bit;

    assign locked_fuses = ~first_lock_bit;

    // Mode 2 and 3 block array programming
    // Reset pin gone: array writes need high voltage
    assign prog_mem_write_ok = (state_reg == LFS_ST_PROG) & mode1 &
                               (high_nv_reg[`LFS_HIGH_RSTDIS] | prog_hv);

    assign prog_verify_ok = (state_reg == LFS_ST_PROG) &
                            (first_lock_bit | second_lock_bit);

    // Reset pin gone: only high-voltage path
    assign fuse_wr_ok = (state_reg == LFS_ST_PROG) & ~locked_fuses &
                        (high_nv_reg[`LFS_HIGH_RSTDIS] | prog_hv);
    assign prog_fuse_write_ok = fuse_wr_ok;

    // Serial enable bit untouchable in serial mode
    always_comb begin
        keep_mask = 8'h00;
        if (!prog_hv && prog_fuse_sel == 2'h3) begin
            keep_mask[`LFS_HIGH_SERPRG] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Lock bits
    // ------------------------------------------------------------

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lock_bits_reg <= `LFS_LOCK_RST;
        end else if (state_reg == LFS_ST_PROG) begin
            if (prog_chip_erase) begin
                // Only chip erase returns bits to 1
                lock_bits_reg <= `LFS_LOCK_RST;
            end else if (prog_lock_wr) begin
                // Writing can only program towards 0
                lock_bits_reg <= lock_bits_reg & prog_wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Fuse cells
    // ------------------------------------------------------------

    // Chip erase is deliberately absent here: fuses survive it.
    // Fuse writes gated by locks
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ext_nv_reg <= `LFS_EXT_RST;
            high_nv_reg <= `LFS_HIGH_RST;
            low_nv_reg <= `LFS_LOW_RST;
        end else if (prog_fuse_wr && fuse_wr_ok) begin
            case (prog_fuse_sel)
                2'h0: low_nv_reg <= prog_wdata;
                2'h2: ext_nv_reg <= prog_wdata;
                2'h3: high_nv_reg <= merge_fuse(high_nv_reg,
                                                prog_wdata, keep_mask);
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Latched fuse copies
    // ------------------------------------------------------------

    // Latch at power-up and session edges
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ext_lat_reg <= `LFS_EXT_RST;
            high_lat_reg <= `LFS_HIGH_RST;
            low_lat_reg <= `LFS_LOW_RST;
        end else if (latch_now) begin
            ext_lat_reg <= ext_nv_reg;
            high_lat_reg <= high_nv_reg;
            low_lat_reg <= low_nv_reg;
        end
    end

    // ------------------------------------------------------------
    // Applied configuration
    // ------------------------------------------------------------

    assign spm_allowed = ~ext_lat_reg[`LFS_EXT_SELFPRG];

    // Debug link off unless mode 1
    assign dbg_link_active = ~high_lat_reg[`LFS_HIGH_DBGEN] & mode1;

    // Debug fuse bypasses the locks for reads
    assign dbg_flash_read_ok = ~high_lat_reg[`LFS_HIGH_DBGEN];

    assign reset_pin_enabled = high_lat_reg[`LFS_HIGH_RSTDIS];

    assign wdt_forced_on = ~high_lat_reg[`LFS_HIGH_WATCHDOG_ALWAYS_ON_FUSE];
    assign wdt_irq_allowed = high_lat_reg[`LFS_HIGH_WATCHDOG_ALWAYS_ON_FUSE];

    // Preserve fuse read from the cell, unlatched
    assign eeprom_preserve = ~high_nv_reg[`LFS_HIGH_EEKEEP];

    assign brownout_level = high_lat_reg[2:0];

    assign clk_out_enable = ~low_lat_reg[`LFS_LOW_CLOCK_OUTPUT_FUSE];

    assign clk_div8 = ~low_lat_reg[`LFS_LOW_DIV8];

    assign startup_time = low_lat_reg[5:4];

    assign clock_source = low_lat_reg[3:0];

    assign osc_cal = CAL_BYTE;

    // ------------------------------------------------------------
    // Chip erase side effect
    // ------------------------------------------------------------

    // Registered so the pulse is clean for the EEPROM sequencer.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            eeprom_erase <= 1'b0;
        end else begin
            eeprom_erase <= prog_chip_erase &
                            (state_reg == LFS_ST_PROG) &
                            ~eeprom_preserve;
        end
    end

    // ------------------------------------------------------------
    // Firmware readout
    // ------------------------------------------------------------

    // No write path exists from the processor side.
    // Read-only readout
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fw_rdata <= 8'hff;
            fw_rvalid <= 1'b0;
        end else begin
            fw_rvalid <= fw_rd;
            if (fw_rd && fw_sig) begin
                case (fw_index[5:0])
                    `LFS_SIG_ID0: fw_rdata <= SIG_BYTE0;
                    `LFS_SIG_CAL: fw_rdata <= CAL_BYTE;
                    `LFS_SIG_ID1: fw_rdata <= SIG_BYTE1;
                    `LFS_SIG_ID2: fw_rdata <= SIG_BYTE2;
                    default: fw_rdata <= `LFS_SIG_RSVD_VAL;
                endcase
            end else if (fw_rd) begin
                if (fw_index == `LFS_IDX_LOCK) begin
                    fw_rdata <= memory_lock_byte;
                end else if (fw_index == `LFS_IDX_LOW ||
                             fw_index == `LFS_IDX_EXT ||
                             fw_index == `LFS_IDX_HIGH) begin
                    fw_rdata <= pick_fuse(fw_index[1:0], low_nv_reg,
                                          ext_nv_reg, high_nv_reg);
                end else begin
                    fw_rdata <= 8'hff;
                end
            end
        end
    end

endmodule // lfs_store

// ---- testbench/lfs_store_props.sv ----
// Port checker for the lock, fuse and signature store.
// Assumes the store's port names; bound after the endmodule.
`timescale 1ns/1ps
module lfs_store_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Programmer side
    input wire logic prog_mode,
    input wire logic prog_chip_erase,
    input wire logic prog_mem_write_ok,
    input wire logic prog_verify_ok,
    input wire logic prog_fuse_write_ok,
    input wire logic eeprom_erase,
    input wire logic eeprom_preserve,
    // Firmware side
    input wire logic fw_rd,
    input wire logic [7:0] fw_rdata,
    input wire logic fw_rvalid,
    // Applied configuration
    input wire logic spm_allowed,
    input wire logic dbg_link_active,
    input wire logic dbg_flash_read_ok,
    input wire logic wdt_forced_on,
    input wire logic wdt_irq_allowed,
    input wire logic clk_div8,
    input wire logic [2:0] brownout_level,
    input wire logic [1:0] startup_time,
    input wire logic [3:0] clock_source
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ----
    // Sequences
    // ----
    // Four edges deep so the entry latch has settled
    sequence s_session;
        prog_mode [*4];
    endsequence
    sequence s_erase_req;
        prog_chip_erase && prog_mode && $past(prog_mode) && !eeprom_preserve;
    endsequence
    // ----
    // Properties
    // ----
    property p_read_answer;
        fw_rd |=> fw_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered next cycle");
    property p_read_quiet;
        !fw_rd |=> !fw_rvalid && $stable(fw_rdata);
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("read data moved without a read");
    property p_latch_hold;
        s_session |-> $stable({spm_allowed, clk_div8, clock_source,
                               startup_time, brownout_level, wdt_forced_on});
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("applied fuses moved inside a session");
    property p_erase_pulse;
        s_erase_req |=> eeprom_erase;
    endproperty
    a_erase_pulse: assert property (p_erase_pulse)
        else $error("chip erase did not clear eeprom");
    property p_erase_cause;
        eeprom_erase |-> $past(prog_chip_erase) && !$past(eeprom_preserve);
    endproperty
    a_erase_cause: assert property (p_erase_cause)
        else $error("eeprom erase without cause");
    property p_perm_session;
        prog_verify_ok || prog_fuse_write_ok |-> $past(prog_mode);
    endproperty
    a_perm_session: assert property (p_perm_session)
        else $error("permission outside a session");
    property p_mode_order;
        prog_mem_write_ok || prog_fuse_write_ok |-> prog_verify_ok;
    endproperty
    a_mode_order: assert property (p_mode_order)
        else $error("verify refused while lower mode permitted");
    property p_wdt;
        wdt_forced_on |-> !wdt_irq_allowed;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog interrupt with forced watchdog");
    property p_dbg;
        dbg_link_active |-> dbg_flash_read_ok;
    endproperty
    a_dbg: assert property (p_dbg)
        else $error("debug link without flash readout");
    property p_defaults;
        $rose(nrst) |-> clk_div8 && clock_source == 4'h2
            && startup_time == 2'h2 && brownout_level == 3'h7 && !spm_allowed;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("wrong configuration out of reset");
endmodule // lfs_store_props

bind lfs_store lfs_store_props u_props (.mclk, .nrst, .prog_mode,
    .prog_chip_erase, .prog_mem_write_ok, .prog_verify_ok,
    .prog_fuse_write_ok, .eeprom_erase, .eeprom_preserve, .fw_rd,
    .fw_rdata, .fw_rvalid, .spm_allowed, .dbg_link_active,
    .dbg_flash_read_ok, .wdt_forced_on, .wdt_irq_allowed, .clk_div8,
    .brownout_level, .startup_time, .clock_source);

// ---- testbench/lfs_prog_model.sv ----
// Programmer model: opens sessions and issues one strobe per call.
// Assumes mclk from the bench; drives only at falling edges.
`timescale 1ns/1ps
module lfs_prog_model (
    // Clock
    input wire logic mclk,
    // Session and strobes
    output logic prog_mode,
    output logic prog_hv,
    output logic prog_fuse_wr,
    output lfs_pkg::lfs_sel_t prog_fuse_sel,
    output logic [7:0] prog_wdata,
    output logic prog_lock_wr,
    output logic prog_chip_erase
);
    import lfs_pkg::*;
    initial begin
        {prog_mode, prog_hv, prog_fuse_wr, prog_lock_wr} = 4'h0;
        prog_chip_erase = 1'b0;
        prog_fuse_sel = 2'h1;
        prog_wdata = 8'h00;
    end
    // Two settle cycles so the latch edge has passed
    task automatic session(input logic on);
        @(negedge mclk);
        prog_mode = on;
        repeat (2) @(negedge mclk);
    endtask
    // Serial or high-voltage session, one settle cycle
    task automatic hv(input logic on);
        @(negedge mclk);
        prog_hv = on;
        @(negedge mclk);
    endtask
    // Kind 0 fuse write, 1 lock write, 2 chip erase
    task automatic strobe(input int kind, input lfs_sel_t sel,
                          input logic [7:0] d);
        @(negedge mclk);
        prog_fuse_sel = sel;
        prog_wdata = d;
        prog_fuse_wr = (kind == 0);
        prog_lock_wr = (kind == 1);
        prog_chip_erase = (kind == 2);
        @(negedge mclk);
        {prog_fuse_wr, prog_lock_wr, prog_chip_erase} = 3'h0;
        // Stale data would hide a late capture
        prog_wdata = ~d;
    endtask
endmodule // lfs_prog_model

// ---- testbench/lock_fuse_signature_store_bench.sv ----
// Self-checking bench for the lock, fuse and signature store.
// Assumes lfs_prog_model as programmer; firmware reads issued here.
`timescale 1ns/1ps
module lock_fuse_signature_store_bench;
    import lfs_pkg::*;
    logic mclk, nrst, fw_rd, fw_sig, fw_rvalid, eeprom_erase, clk_div8;
    logic prog_mode, prog_hv, prog_fuse_wr, prog_lock_wr, prog_chip_erase;
    lfs_sel_t prog_fuse_sel;
    logic [7:0] prog_wdata, fw_rdata, osc_cal, rnd;
    logic [15:0] fw_index;
    logic prog_mem_write_ok, prog_verify_ok, prog_fuse_write_ok;
    logic spm_allowed, dbg_link_active, dbg_flash_read_ok, eeprom_preserve;
    logic reset_pin_enabled, wdt_forced_on, wdt_irq_allowed, clk_out_enable;
    logic [2:0] brownout_level;
    logic [1:0] startup_time;
    logic [3:0] clock_source;
    logic [7:0] exp_q[$];
    logic [7:0] idx_t[5] = '{8'h62, 8'hff, 8'hff, 8'hdf, 8'hff};
    logic [7:0] sig_t[6] = '{8'h5a, 8'h80, 8'h01, 8'hff, 8'h02, 8'hff};
    int errors = 0;
    int comparisons = 0;
    int erase_seen = 0;
    int seed = 32'h556c;
    wire logic [7:0] clk_grp = {clk_div8, clk_out_enable, startup_time,
                                clock_source};
    wire logic [7:0] cfg_grp = {spm_allowed, reset_pin_enabled,
        wdt_forced_on, wdt_irq_allowed, eeprom_preserve, brownout_level};
    wire logic [7:0] perm_grp = {3'h0, dbg_link_active, dbg_flash_read_ok,
        prog_mem_write_ok, prog_verify_ok, prog_fuse_write_ok};
    // Signature parameters left at their arbitrary defaults
    lfs_store dut (.mclk, .nrst, .prog_mode, .prog_hv,
        .prog_fuse_wr, .prog_fuse_sel, .prog_wdata, .prog_lock_wr,
        .prog_chip_erase, .prog_mem_write_ok, .prog_verify_ok,
        .prog_fuse_write_ok, .eeprom_erase, .fw_rd, .fw_sig, .fw_index,
        .fw_rdata, .fw_rvalid, .spm_allowed, .dbg_link_active,
        .dbg_flash_read_ok, .reset_pin_enabled, .wdt_forced_on,
        .wdt_irq_allowed, .eeprom_preserve, .brownout_level,
        .clk_out_enable, .clk_div8, .startup_time, .clock_source, .osc_cal);
    lfs_prog_model prog (.mclk, .prog_mode, .prog_hv, .prog_fuse_wr,
        .prog_fuse_sel, .prog_wdata, .prog_lock_wr, .prog_chip_erase);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s %h not %h", $time, what,
                     seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rd(input logic s, input logic [15:0] i,
                      input logic [7:0] e);
        @(negedge mclk);
        fw_rd = 1'b1;
        fw_sig = s;
        fw_index = i;
        exp_q.push_back(e);
        @(negedge mclk);
        fw_rd = 1'b0;
        fw_index = ~i;
    endtask
    task automatic drain();
        for (int n = 0; n < 20 && exp_q.size() > 0; n++)
            @(negedge mclk);
        if (exp_q.size() > 0)
            check(8'h00, 8'h01, "answer missing");
    endtask
    always @(posedge mclk) begin
        #1;
        if (eeprom_erase === 1'b1)
            erase_seen++;
        if (fw_rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                check(8'h00, 8'h01, "stray answer");
            else
                check(fw_rdata, exp_q.pop_front(), "readout");
        end
    end
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        check(8'h00, 8'h01, "timeout");
        close_out();
    end
    initial begin
        nrst = 1'b0;
        fw_rd = 1'b0;
        fw_sig = 1'b0;
        fw_index = 16'h0;
        rnd = 8'($random(seed));
        repeat (6) @(negedge mclk);
        nrst = 1'b1;
        repeat (2) @(negedge mclk);
        check(clk_grp, 8'ha2, "clock defaults");
        check(cfg_grp, 8'h57, "config defaults");
        check(osc_cal, 8'h80, "calibration");
        for (int i = 0; i < 5; i++)
            rd(1'b0, 16'(i), idx_t[i]);
        for (int i = 0; i < 6; i++)
            rd(1'b1, 16'(i), sig_t[i]);
        rd(1'b1, 16'h002a, 8'hff);
        drain();
        $display("done: defaults and tables");
        prog.session(1'b1);
        check(perm_grp, 8'h07, "open perms");
        prog.strobe(2, 2'h0, 8'h00);
        prog.strobe(0, 2'h0, rnd);
        prog.strobe(0, 2'h2, 8'hfe);
        prog.strobe(0, 2'h3, 8'he7);
        rd(1'b0, 16'h0, rnd);
        rd(1'b0, 16'h2, 8'hfe);
        rd(1'b0, 16'h3, 8'hc7);
        drain();
        check(clk_grp, 8'ha2, "held clock");
        check(cfg_grp, 8'h5f, "early preserve");
        prog.session(1'b0);
        check(clk_grp, rnd ^ 8'hc0, "clock applied");
        check(cfg_grp, 8'hef, "config applied");
        check(perm_grp, 8'h00, "closed");
        $display("done: fuse session");
        prog.session(1'b1);
        prog.strobe(1, 2'h0, 8'hfe);
        rd(1'b0, 16'h1, 8'hfe);
        drain();
        check(perm_grp, 8'h02, "mode two");
        prog.strobe(0, 2'h0, 8'h00);
        prog.strobe(1, 2'h0, 8'hff);
        rd(1'b0, 16'h0, rnd);
        rd(1'b0, 16'h1, 8'hfe);
        prog.strobe(1, 2'h0, 8'hfc);
        rd(1'b0, 16'h1, 8'hfc);
        drain();
        check(perm_grp, 8'h00, "mode three");
        prog.strobe(2, 2'h0, 8'h00);
        rd(1'b0, 16'h1, 8'hff);
        rd(1'b0, 16'h0, rnd);
        drain();
        check(perm_grp, 8'h07, "erased");
        check(8'(erase_seen), 8'h01, "erase pulses");
        $display("done: lock modes");
        // Serial session: reset pin and debug fuses programmed
        prog.strobe(0, 2'h3, 8'h27);
        rd(1'b0, 16'h3, 8'h07);
        drain();
        check(perm_grp, 8'h02, "serial after reset fuse");
        prog.strobe(0, 2'h3, 8'hff);
        rd(1'b0, 16'h3, 8'h07);
        prog.hv(1'b1);
        check(perm_grp, 8'h07, "high voltage");
        prog.strobe(0, 2'h3, 8'h27);
        rd(1'b0, 16'h3, 8'h27);
        drain();
        prog.session(1'b0);
        check(perm_grp, 8'h18, "debug applied");
        check(cfg_grp, 8'haf, "reset pin gone");
        prog.hv(1'b0);
        $display("done: high-voltage session");
        close_out();
    end
endmodule // lock_fuse_signature_store_bench
